// file: rtl/ipf_fifo.sv
`timescale 1ns/1ps
module ipf_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             flush,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic      [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0]        mem_q [DEPTH];
   logic [AW-1:0]           wr_q, wr_d, rd_q, rd_d;
   logic [$clog2(DEPTH+1)-1:0] cnt_q, cnt_d;
   logic                    push, pop;

   assign in_ready  = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign count     = cnt_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (flush) begin
         wr_d  = '0;
         rd_d  = '0;
         cnt_d = '0;
      end else begin
         if (push) wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)  rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         if (push && !pop) cnt_d = cnt_q + 1'b1;
         if (pop && !push) cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage has no reset; only pointers and count matter
   always_ff @(posedge clock) begin
      if (push && !flush) mem_q[wr_q] <= in_data;
   end
endmodule

// file: rtl/ipf_frontend.sv
`timescale 1ns/1ps
module ipf_frontend #(
   parameter int RAW_DEPTH = ipf_pkg::RAW_DEPTH,
   parameter int DEC_DEPTH = ipf_pkg::DEC_DEPTH,
   parameter int OUT_DEPTH = 32
) (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   // mode and code segment
   input  wire logic                       prot_mode,
   input  wire logic [ipf_pkg::ADDR_W-1:0] code_base,
   input  wire logic [ipf_pkg::OFS_W-1:0]  code_limit,
   // control transfer
   input  wire logic                       jump_valid,
   input  wire logic [ipf_pkg::OFS_W-1:0]  jump_ofs,
   // operand requests from execute
   input  wire logic                       op_req,
   input  wire logic                       op_write,
   input  wire logic [ipf_pkg::ADDR_W-1:0] op_seg_base,
   input  wire logic [ipf_pkg::OFS_W-1:0]  op_ofs,
   input  wire logic [ipf_pkg::OFS_W-1:0]  op_limit,
   input  wire logic [ipf_pkg::DATA_W-1:0] op_wdata,
   output logic                            op_done,
   output logic                            op_fault,
   output logic [ipf_pkg::DATA_W-1:0]      op_rdata,
   // local bus
   output logic                            bus_req,
   output logic                            bus_write,
   output logic                            bus_code,
   output logic [ipf_pkg::ADDR_W-1:0]      bus_addr,
   output logic [ipf_pkg::DATA_W-1:0]      bus_wdata,
   input  wire logic                       bus_ready,
   input  wire logic [ipf_pkg::DATA_W-1:0] bus_rdata,
   // decoded instructions to execute
   output logic                            ins_valid,
   input  wire logic                       ins_ready,
   output logic [ipf_pkg::DATA_W-1:0]      ins_data
);
   // ----------------------------------------------------------------
   // bus unit
   // ----------------------------------------------------------------
   ipf_pkg::ipf_bus_e             st_q, st_d;
   logic [ipf_pkg::OFS_W-1:0]     pc_q, pc_d;
   logic [ipf_pkg::ADDR_W-1:0]    addr_q, addr_d;
   logic                          req_q, req_d, wr_q, wr_d, code_q, code_d;
   logic [ipf_pkg::DATA_W-1:0]    wd_q, wd_d, rd_q, rd_d;
   logic                          done_q, done_d, fault_q, fault_d;
   logic [7:0]                    raw_q [RAW_DEPTH];
   logic [7:0]                    raw_d [RAW_DEPTH];
   logic [2:0]                    rcnt_q, rcnt_d;
   logic                          stale_q, stale_d;
   logic [ipf_pkg::ADDR_W-1:0]    mask, op_phys, code_phys;
   logic                          room, in_limit, take_byte;
   logic                          dec_ready, dec_valid, dec_valid_full;
   logic [ipf_pkg::DATA_W-1:0]    dec_word;
   logic                          dec_hi_q, dec_hi_d;
   logic [7:0]                    dec_lo_q, dec_lo_d;

   assign mask      = prot_mode ? ipf_pkg::PROT_MASK : ipf_pkg::REAL_MASK;
   assign op_phys   = (op_seg_base + {8'h00, op_ofs}) & mask;
   assign code_phys = (code_base + {8'h00, pc_q}) & mask;
   assign in_limit  = (pc_q <= code_limit);
   assign room      = (int'(rcnt_q) + ipf_pkg::WORD_BYTES) <= RAW_DEPTH;
   assign take_byte = (rcnt_q != '0) && !dec_valid_full;

   always_comb begin
      st_d    = st_q;
      pc_d    = pc_q;
      addr_d  = addr_q;
      req_d   = req_q;
      wr_d    = wr_q;
      code_d  = code_q;
      wd_d    = wd_q;
      rd_d    = rd_q;
      done_d  = 1'b0;
      fault_d = 1'b0;
      rcnt_d  = rcnt_q;
      raw_d   = raw_q;
      stale_d = stale_q;
      dec_hi_d = dec_hi_q;
      dec_lo_d = dec_lo_q;
      dec_valid = 1'b0;
      dec_word  = {dec_lo_q, raw_q[0]};
      // decode pairs bytes concurrently with fetch
      if (take_byte) begin
         for (int i = 0; i < RAW_DEPTH - 1; i++) raw_d[i] = raw_q[i+1];
         rcnt_d = rcnt_q - 3'd1;
         if (dec_hi_q) begin
            dec_valid = 1'b1;
            dec_hi_d  = 1'b0;
         end else begin
            dec_lo_d = raw_q[0];
            dec_hi_d = 1'b1;
         end
      end
      case (st_q)
         ipf_pkg::IPF_IDLE: begin
            if (op_req && !done_q) begin
               if ({8'h00, op_ofs} > {8'h00, op_limit}) begin
                  fault_d = 1'b1;
                  done_d  = 1'b1;
               end else begin
                  st_d   = ipf_pkg::IPF_DATA;
                  req_d  = 1'b1;
                  wr_d   = op_write;
                  code_d = 1'b0;
                  addr_d = op_phys;
                  wd_d   = op_wdata;
               end
            end else if (in_limit && room && !jump_valid) begin
               st_d    = ipf_pkg::IPF_FETCH;
               req_d   = 1'b1;
               wr_d    = 1'b0;
               code_d  = 1'b1;
               addr_d  = code_phys;
               stale_d = 1'b0;
            end
         end
         ipf_pkg::IPF_FETCH: begin
            if (bus_ready) begin
               st_d  = ipf_pkg::IPF_IDLE;
               req_d = 1'b0;
               if (!stale_q && !jump_valid) begin
                  raw_d[rcnt_d]      = bus_rdata[7:0];
                  raw_d[rcnt_d+3'd1] = bus_rdata[15:8];
                  rcnt_d = rcnt_d + 3'd2;
                  pc_d   = pc_q + ipf_pkg::OFS_STEP;
               end
            end
         end
         ipf_pkg::IPF_DATA: begin
            if (bus_ready) begin
               st_d   = ipf_pkg::IPF_IDLE;
               req_d  = 1'b0;
               rd_d   = bus_rdata;
               done_d = 1'b1;
            end
         end
         default: st_d = ipf_pkg::IPF_IDLE;
      endcase
      if (jump_valid) begin
         pc_d     = jump_ofs;
         rcnt_d   = '0;
         dec_hi_d = 1'b0;
         if (st_q == ipf_pkg::IPF_FETCH && !bus_ready) stale_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_q     <= ipf_pkg::IPF_IDLE;
         pc_q     <= '0;
         addr_q   <= '0;
         req_q    <= 1'b0;
         wr_q     <= 1'b0;
         code_q   <= 1'b0;
         wd_q     <= '0;
         rd_q     <= '0;
         done_q   <= 1'b0;
         fault_q  <= 1'b0;
         rcnt_q   <= '0;
         stale_q  <= 1'b0;
         dec_hi_q <= 1'b0;
         dec_lo_q <= '0;
         for (int i = 0; i < RAW_DEPTH; i++) raw_q[i] <= '0;
      end else begin
         st_q     <= st_d;
         pc_q     <= pc_d;
         addr_q   <= addr_d;
         req_q    <= req_d;
         wr_q     <= wr_d;
         code_q   <= code_d;
         wd_q     <= wd_d;
         rd_q     <= rd_d;
         done_q   <= done_d;
         fault_q  <= fault_d;
         rcnt_q   <= rcnt_d;
         stale_q  <= stale_d;
         dec_hi_q <= dec_hi_d;
         dec_lo_q <= dec_lo_d;
         raw_q    <= raw_d;
      end
   end

   assign bus_req   = req_q;
   assign bus_write = wr_q;
   assign bus_code  = code_q;
   // upper lines zero in compatibility mode
   assign bus_addr  = addr_q;
   assign bus_wdata = wd_q;
   assign op_done   = done_q;
   assign op_fault  = fault_q;
   assign op_rdata  = rd_q;

   // ----------------------------------------------------------------
   // decoded queue and output buffer
   // ----------------------------------------------------------------
   logic       dq_valid, dq_ready, ob_valid;
   logic [ipf_pkg::DATA_W-1:0] dq_data, ob_data;
   logic [$clog2(DEC_DEPTH+1)-1:0] dq_cnt;
   logic       ins_valid_q, ins_valid_d;
   logic [ipf_pkg::DATA_W-1:0] ins_data_q, ins_data_d;
   logic       ob_ready;

   assign dec_valid_full = dec_hi_q && !dec_ready;

   ipf_fifo #(.WIDTH(ipf_pkg::DATA_W), .DEPTH(DEC_DEPTH)) u_decq (
      .clock     (clock),
      .arst_n    (arst_n),
      .flush     (jump_valid),
      .in_valid  (dec_valid),
      .in_ready  (dec_ready),
      .in_data   (dec_word),
      .out_valid (dq_valid),
      .out_ready (dq_ready),
      .out_data  (dq_data),
      .count     (dq_cnt)
   );

   // output buffer, back-pressure reaches decode
   ipf_fifo #(.WIDTH(ipf_pkg::DATA_W), .DEPTH(OUT_DEPTH)) u_outq (
      .clock     (clock),
      .arst_n    (arst_n),
      .flush     (jump_valid),
      .in_valid  (dq_valid),
      .in_ready  (dq_ready),
      .in_data   (dq_data),
      .out_valid (ob_valid),
      .out_ready (ob_ready),
      .out_data  (ob_data),
      .count     ()
   );

   assign ob_ready = !ins_valid_q || ins_ready;

   always_comb begin
      ins_valid_d = ins_valid_q;
      ins_data_d  = ins_data_q;
      if (jump_valid) begin
         ins_valid_d = 1'b0;
      end else if (ob_ready) begin
         ins_valid_d = ob_valid;
         ins_data_d  = ob_data;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ins_valid_q <= 1'b0;
         ins_data_q  <= '0;
      end else begin
         ins_valid_q <= ins_valid_d;
         ins_data_q  <= ins_data_d;
      end
   end

   assign ins_valid = ins_valid_q;
   assign ins_data  = ins_data_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_raw_bound: assert property (@(posedge clock) disable iff (!arst_n) rcnt_q <= RAW_DEPTH)
      else $error("raw queue overfilled");
   chk_dec_bound: assert property (@(posedge clock) disable iff (!arst_n) dq_cnt <= DEC_DEPTH)
      else $error("decoded queue overfilled");
   chk_real_width: assert property (@(posedge clock) disable iff (!arst_n)
      (req_q && !prot_mode && $rose(req_q)) |-> addr_q[23:20] == 4'h0) else $error("upper lines set in real mode");
   chk_limit_stop: assert property (@(posedge clock) disable iff (!arst_n)
      (st_q == ipf_pkg::IPF_IDLE && !in_limit) |=> st_q != ipf_pkg::IPF_FETCH) else $error("fetch past limit");
   chk_op_first: assert property (@(posedge clock) disable iff (!arst_n)
      (st_q == ipf_pkg::IPF_IDLE && op_req && !done_q && op_ofs <= op_limit) |=> st_q == ipf_pkg::IPF_DATA)
      else $error("prefetch beat operand");
   chk_flush_empty: assert property (@(posedge clock) disable iff (!arst_n) jump_valid |=> rcnt_q == 3'd0)
      else $error("queue not flushed");
   chk_seq_fetch: assert property (@(posedge clock) disable iff (!arst_n)
      (st_q == ipf_pkg::IPF_FETCH && bus_ready && !stale_q && !jump_valid) |=> pc_q == $past(pc_q) + ipf_pkg::OFS_STEP)
      else $error("fetch not sequential");
   chk_room_stall: assert property (@(posedge clock) disable iff (!arst_n)
      (st_q == ipf_pkg::IPF_IDLE && !room) |=> st_q != ipf_pkg::IPF_FETCH) else $error("fetch without room");
endmodule

// file: rtl/ipf_pkg.sv
// Functional notes
// - The bus unit fetches instruction words whenever no operand transfer is pending and the raw byte queue has room for a word.
// - Each fetch targets the address right after the bytes already fetched.
// - Fetching stops once the fetch offset passes the code segment limit.
// - A control transfer flushes all queued bytes and restarts fetching at the target.
// - The raw byte queue holds six bytes and hands them to decode in order.
// - Decode moves bytes into a decoded queue three entries deep that drains through a 32-entry output buffer and a register to execute.
// - Execute performs operand transfers only by requests to the bus unit.
// - Address translation turns every logical address into a physical one with a limit check.
// - In compatibility mode physical addresses are 20 bits wide.
// - In protected mode physical addresses are 24 bits wide.
// - Fetch, decode, execute and translation run concurrently.
// - The local bus has a 24-bit address and a separate 16-bit data path.
package ipf_pkg;
   localparam int             ADDR_W     = 24;
   localparam int             DATA_W     = 16;
   localparam int             OFS_W      = 16;
   localparam int             RAW_DEPTH  = 6;
   localparam int             DEC_DEPTH  = 3;
   localparam int             WORD_BYTES = 2;
   localparam logic [23:0]    REAL_MASK  = 24'h0fffff;
   localparam logic [23:0]    PROT_MASK  = 24'hffffff;
   localparam logic [15:0]    OFS_STEP   = 16'h0002;
   localparam logic [23:0]    SEG_SHIFT  = 24'h000004;
   typedef enum logic [1:0] {
      IPF_IDLE,
      IPF_FETCH,
      IPF_DATA
   } ipf_bus_e;
endpackage

// file: testbench/ipf_frontend_tb.sv
`timescale 1ns/1ps
module ipf_frontend_tb;
   logic clock = 0, arst_n = 0, prot_mode = 1, jump_valid = 0, op_req = 0, op_write = 0, ins_ready = 0;
   logic [23:0] code_base = 24'h012340, op_seg_base = 24'h000000;
   logic [15:0] code_limit = 16'hffff, jump_ofs = 16'h0000, op_ofs = 16'h0000;
   logic [15:0] op_limit = 16'hffff, op_wdata = 16'h0000;
   logic        op_done, op_fault, bus_req, bus_write, bus_code, bus_ready, ins_valid;
   logic [15:0] op_rdata, bus_wdata, bus_rdata, ins_data;
   logic [23:0] bus_addr;
   int          wait_cyc = 0;
   int          err_count = 0;
   int          num_checks = 0;
   always #12.5 clock = ~clock;
   ipf_frontend ipf_frontend_inst (.clock(clock), .arst_n(arst_n), .prot_mode(prot_mode),
      .code_base(code_base), .code_limit(code_limit), .jump_valid(jump_valid), .jump_ofs(jump_ofs),
      .op_req(op_req), .op_write(op_write), .op_seg_base(op_seg_base), .op_ofs(op_ofs),
      .op_limit(op_limit), .op_wdata(op_wdata), .op_done(op_done), .op_fault(op_fault),
      .op_rdata(op_rdata), .bus_req(bus_req), .bus_write(bus_write), .bus_code(bus_code),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_rdata(bus_rdata),
      .ins_valid(ins_valid), .ins_ready(ins_ready), .ins_data(ins_data));
   ipf_mem_model ipf_mem_model_inst (.clock(clock), .arst_n(arst_n), .prot_mode(prot_mode),
      .wait_cyc(wait_cyc), .bus_req(bus_req), .bus_write(bus_write), .bus_code(bus_code),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_rdata(bus_rdata));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // expected decoded word for a code offset: bytes n then n+1
   function automatic logic [15:0] exp_word(input logic [15:0] ofs);
      logic [23:0] a;
      a = (code_base + ofs) & (prot_mode ? 24'hffffff : 24'h0fffff);
      return {a[7:0], a[7:0] + 8'h01};
   endfunction
   task automatic get_ins(input logic [15:0] ofs);
      int i;
      for (i = 0; i < 200 && !(ins_valid === 1'b1 && ins_ready === 1'b1); i++) @(posedge clock);
      chk("ins handshake", 24'h1, {23'h0, i < 200});
      chk("ins_data", {8'h00, exp_word(ofs)}, {8'h00, ins_data});
      @(posedge clock);
   endtask
   task automatic jump(input logic [15:0] ofs);
      jump_valid <= 1'b1;
      jump_ofs <= ofs;
      @(posedge clock);
      jump_valid <= 1'b0;
      @(posedge clock);
   endtask
   task automatic op(input logic wr, input logic [15:0] ofs, input logic [15:0] lim, output logic flt);
      int i;
      op_req <= 1'b1;
      op_write <= wr;
      op_ofs <= ofs;
      op_limit <= lim;
      op_wdata <= 16'hbeef;
      op_seg_base <= 24'hab0000;
      @(posedge clock);
      for (i = 0; i < 200 && op_done !== 1'b1; i++) @(posedge clock);
      chk("op done", 24'h1, {23'h0, i < 200});
      flt = op_fault;
      op_req <= 1'b0;
      @(posedge clock);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_stream;
      int fc;
      repeat (400) @(posedge clock);
      fc = ipf_mem_model_inst.fetch_cnt;
      repeat (40) @(posedge clock);
      chk("stalled fetches", fc, ipf_mem_model_inst.fetch_cnt);
      ins_ready <= 1'b1;
      // drain everything buffered, then the stream keeps running in order
      for (int k = 0; k < 40; k++) get_ins(16'(2 * k));
      $display("test stream done, errors %0d", err_count);
   endtask
   task automatic t_limit;
      wait_cyc = 3;
      ins_ready <= 1'b0;
      prot_mode <= 1'b0;
      code_base <= 24'hf00100;
      code_limit <= 16'h000f;
      @(posedge clock);
      jump(16'h0004);
      ins_ready <= 1'b1;
      for (int k = 0; k < 6; k++) get_ins(16'(4 + 2 * k));
      repeat (60) @(posedge clock);
      chk("valid past limit", 24'h0, {23'h0, ins_valid});
      chk("last code addr", 24'h00010e, ipf_mem_model_inst.last_code);
      $display("test limit done, errors %0d", err_count);
   endtask
   task automatic t_op;
      logic flt;
      int   fc;
      int   dc;
      wait_cyc = 1;
      prot_mode <= 1'b1;
      code_base <= 24'h012340;
      code_limit <= 16'hffff;
      @(posedge clock);
      jump(16'h0000);
      repeat (5) @(posedge clock);
      fc = ipf_mem_model_inst.fetch_cnt;
      op(1'b0, 16'h1234, 16'hffff, flt);
      chk("prefetches before op", 24'h1, {23'h0, (ipf_mem_model_inst.fetch_cnt - fc) <= 1});
      chk("read fault", 24'h0, {23'h0, flt});
      chk("read addr", 24'hab1234, ipf_mem_model_inst.last_data);
      chk("read data", 24'h003534, {8'h00, op_rdata});
      op(1'b1, 16'h0102, 16'hffff, flt);
      chk("write data", 24'h00beef, {8'h00, ipf_mem_model_inst.wr_data});
      dc = ipf_mem_model_inst.data_cnt;
      op(1'b0, 16'h0100, 16'h00ff, flt);
      chk("limit fault", 24'h1, {23'h0, flt});
      chk("no bus on fault", dc, ipf_mem_model_inst.data_cnt);
      repeat (20) @(posedge clock);
      chk("fetch resumed", 24'h1, {23'h0, ipf_mem_model_inst.fetch_cnt > fc + 1});
      $display("test op done, errors %0d", err_count);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      t_stream();
      t_limit();
      t_op();
      end_sim();
   end
   // hang guard, far beyond the several hundred cycles the tests need
   initial begin
      #500000;
      err_count++;
      end_sim();
   end
endmodule

// file: testbench/ipf_mem_model.sv
`timescale 1ns/1ps
module ipf_mem_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        prot_mode,
   input  wire logic [31:0] wait_cyc,
   // local bus
   input  wire logic        bus_req,
   input  wire logic        bus_write,
   input  wire logic        bus_code,
   input  wire logic [23:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   output logic             bus_ready,
   output logic      [15:0] bus_rdata
);
   int          fetch_cnt;
   int          data_cnt;
   int          cnt;
   logic [23:0] last_code;
   logic [23:0] last_data;
   logic [23:0] dec_addr;
   logic [15:0] wr_data;
   assign dec_addr = prot_mode ? bus_addr : {4'h0, bus_addr[19:0]};
   // word read, low byte at even address
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_ready <= 1'b0;
         bus_rdata <= 16'h0000;
         cnt = 0;
         fetch_cnt = 0;
         data_cnt = 0;
      end else if (bus_ready) begin
         // released data lines must not look valid
         bus_ready <= 1'b0;
         bus_rdata <= ~bus_rdata;
         cnt = 0;
      end else if (bus_req) begin
         if (cnt >= wait_cyc) begin
            bus_ready <= 1'b1;
            bus_rdata <= {dec_addr[7:0] + 8'h01, dec_addr[7:0]};
            if (bus_code) begin
               fetch_cnt++;
               // raw lines, so a missing mode mask in the design shows up
               last_code = bus_addr;
            end else begin
               data_cnt++;
               last_data = bus_addr;
               if (bus_write) wr_data = bus_wdata;
            end
         end else cnt++;
      end
   end
endmodule
